// >>> param_channel_mode_toggle.sv
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Function
// [R01] master codes requests: 03 none, 13 read, 23 word, 33 dword write
// [R02] response 03 while pending, 13 word success, 23 dword success
// [R03] failed request returns 73 at once in the same image
// [R04] only one request handled at a time, nothing queued
// [R05] last response repeated every cycle until a new request
// [R06] repeated value responses carry the parameter's current value
// [R07] read starts only on a 03 to 13 change
// [R08] write starts only on 03 to 23 or 03 to 33
// [R09] read ignores the request value and returns parameter value
// [R10] write stores request value and returns resulting value
// [R11] failure puts error number in the response value field
// [R12] master sends 03 for one exchange before the next request
// [R13] unknown parameter reports error number 1101 with error code
// [R14] master toggles mode bit; status reports toggle and fault bits
// [R15] both edges of the commanded toggle bit start an action
// [R16] on accept echo toggle and clear done in same response
// [R17] done flag set when the started movement finishes
// [R18] master polls toggle echo and done flag after starting
// [R19] master uses toggle echo to spot very short movements
// [R20] header: index bits 0-15, subindex 16-23, control 24-31
// [R21] mode command selects state and mode and carries toggle bit
// [R22] mode status shows active mode with toggle echo and fault
// [R23] index and subindex copied into response header always
// [R24] master keeps fields stable while a request is asserted
module param_channel_mode_toggle
    import param_channel_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // cyclic image from the master
    input wire logic [31:0] request_header_out,
    input wire logic [31:0] request_value_out,
    input wire logic [15:0] drive_mode_command_word,
    // cyclic image to the master
    output logic [31:0] response_header_in,
    output logic [31:0] response_value_in,
    output logic [15:0] mode_status_word,
    // drive operating state selected by the master
    output logic [7:0] drive_state_sel,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    typedef struct packed {
        logic [31:0] hdr_s1;
        logic [31:0] hdr_s2;
        logic [31:0] val_s1;
        logic [31:0] val_s2;
        logic [15:0] mcmd_s1;
        logic [15:0] mcmd_s2;
        logic [7:0] prev_ctrl;
        logic [7:0] resp_ctrl;
        logic [7:0] resp_sub;
        logic [15:0] resp_index;
        logic [31:0] resp_err;
        logic resp_has_val;
        logic [1:0] resp_slot;
        logic [31:0] resp_value;
        logic [NUM_PARAMS*32-1:0] params;
        logic toggle_echo;
        logic toggle_prev;
        logic mode_fault;
        logic [7:0] active_mode;
        logic [7:0] state_sel;
        logic [15:0] move_len;
        logic [31:0] prdata;
    } st_t;

    st_t s_reg;
    st_t s_next;
    logic move_start;
    logic move_busy;
    header_t req;
    apb_req_t apb;

    // parameter lookup: returns slot and hit flag
    function automatic logic [2:0] find_param(input header_t h);
        logic [2:0] r;
        r = 3'b000;
        if (h.sub == PSUB_BASE && h.index >= PIDX_BASE &&
            h.index < PIDX_BASE + 16'(NUM_PARAMS)) begin
            r = {1'b1, 2'(h.index - PIDX_BASE)};
        end
        return r;
    endfunction : find_param

    function automatic logic [31:0] param_at(input st_t s,
                                             input logic [1:0] k);
        return s.params[k*32 +: 32];
    endfunction : param_at

    move_timer u_move (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(move_start),
        .length(s_reg.move_len),
        .busy(move_busy)
    );

    assign req = unpack_hdr(s_reg.hdr_s2);
    assign apb = '{psel: psel, penable: penable, pwrite: pwrite,
                   paddr: paddr, pwdata: pwdata};
    // a toggle edge in either direction starts a move [R15]
    assign move_start = s_reg.mcmd_s2[MCMD_TOGGLE_BIT] != s_reg.toggle_prev;

    // next-state logic for the channel, mode handshake and apb
    always_comb begin
        logic [2:0] hit;
        logic is_edge;
        logic chan_wr;
        hit = 3'b000;
        is_edge = 1'b0;
        chan_wr = 1'b0;
        s_next = s_reg;
        // image inputs come from another domain: two stages first
        s_next.hdr_s1 = request_header_out;
        s_next.hdr_s2 = s_reg.hdr_s1;
        s_next.val_s1 = request_value_out;
        s_next.val_s2 = s_reg.val_s1;
        s_next.mcmd_s1 = drive_mode_command_word;
        s_next.mcmd_s2 = s_reg.mcmd_s1;
        s_next.prev_ctrl = req.ctrl;

        // only a change away from 03 is a request edge [R07] [R08]
        is_edge = (s_reg.prev_ctrl == CTRL_NONE) &&
                  (req.ctrl != CTRL_NONE);
        if (is_edge) begin
            // one request at a time, taken whole, nothing queued [R04]
            hit = find_param(req);
            s_next.resp_sub = req.sub; // [R23]
            s_next.resp_index = req.index; // [R23]
            s_next.resp_has_val = 1'b0;
            s_next.resp_slot = hit[1:0];
            if (req.ctrl == CTRL_READ) begin
                if (hit[2]) begin
                    // request value ignored on reads [R09]
                    s_next.resp_ctrl = RESP_OK_DWORD; // [R02]
                    s_next.resp_has_val = 1'b1;
                end else begin
                    s_next.resp_ctrl = RESP_ERROR; // [R03]
                    s_next.resp_err = ERR_NO_PARAM; // [R13]
                end
            end else if (req.ctrl == CTRL_WR_WORD ||
                         req.ctrl == CTRL_WR_DWORD) begin
                if (!hit[2]) begin
                    s_next.resp_ctrl = RESP_ERROR; // [R03]
                    s_next.resp_err = ERR_NO_PARAM; // [R13]
                end else if (hit[1:0] == 2'd3) begin
                    // last slot is read-only: shows the move length
                    s_next.resp_ctrl = RESP_ERROR; // [R03]
                    s_next.resp_err = ERR_READ_ONLY; // [R11]
                end else begin
                    // a word write touches the low half only [R10]
                    if (req.ctrl == CTRL_WR_WORD) begin
                        s_next.params[hit[1:0]*32 +: 16] = s_reg.val_s2[15:0];
                        s_next.resp_ctrl = RESP_OK_WORD; // [R02]
                    end else begin
                        s_next.params[hit[1:0]*32 +: 32] = s_reg.val_s2;
                        s_next.resp_ctrl = RESP_OK_DWORD; // [R02]
                    end
                    s_next.resp_has_val = 1'b1;
                    chan_wr = 1'b1;
                end
            end else begin
                // unknown control code: refuse it the same way
                s_next.resp_ctrl = RESP_ERROR; // [R03]
                s_next.resp_err = ERR_NO_PARAM; // [R11]
            end
        end else if (req.ctrl == CTRL_NONE) begin
            // idle channel shows pending code, header still echoed
            s_next.resp_ctrl = RESP_PENDING; // [R02]
            s_next.resp_sub = req.sub;
            s_next.resp_index = req.index;
            s_next.resp_has_val = 1'b0;
            s_next.resp_err = 32'h0000_0000;
        end
        // otherwise the last response simply stands [R05]

        // slot 3 mirrors the move length, always current
        s_next.params[3*32 +: 32] = {16'h0000, s_reg.move_len};

        // value field refreshed every cycle from the live table [R06]
        if (s_next.resp_has_val) begin
            s_next.resp_value = param_at(s_next, s_next.resp_slot); // [R10]
        end else begin
            s_next.resp_value = s_next.resp_err; // [R11]
        end

        // mode command selects state and mode [R21]
        s_next.state_sel = s_reg.mcmd_s2[MCMD_STATE_LSB +: 8];
        if (move_start) begin
            s_next.toggle_prev = s_reg.mcmd_s2[MCMD_TOGGLE_BIT];
            s_next.toggle_echo = s_reg.mcmd_s2[MCMD_TOGGLE_BIT]; // [R16]
            s_next.active_mode = {1'b0,
                                  s_reg.mcmd_s2[MCMD_MODE_LSB +: 7]};
            // zero length move cannot run: flag it
            s_next.mode_fault = (s_reg.move_len == 16'h0000); // [R14]
        end

        // apb: reads latched in the setup phase, writes take effect in the access phase
        s_next.prdata = 32'h0000_0000;
        if (apb.psel && !apb.penable && !apb.pwrite) begin
            case (apb.paddr)
                OFF_PARAM0: s_next.prdata = param_at(s_reg, 2'd0);
                OFF_PARAM1: s_next.prdata = param_at(s_reg, 2'd1);
                OFF_PARAM2: s_next.prdata = param_at(s_reg, 2'd2);
                OFF_PARAM3: s_next.prdata = param_at(s_reg, 2'd3);
                OFF_STATUS: s_next.prdata = {16'h0000, mode_status_word};
                OFF_MOVE_LEN: s_next.prdata = {16'h0000, s_reg.move_len};
                default: s_next.prdata = 32'h0000_0000;
            endcase
        end
        // software parameter writes lose to a same-cycle channel write; move length writes still land
        if (apb.psel && apb.penable && apb.pwrite && !chan_wr) begin
            case (apb.paddr)
                OFF_PARAM0: s_next.params[0 +: 32] = apb.pwdata;
                OFF_PARAM1: s_next.params[32 +: 32] = apb.pwdata;
                OFF_PARAM2: s_next.params[64 +: 32] = apb.pwdata;
                OFF_MOVE_LEN: s_next.move_len = apb.pwdata[15:0];
                default: s_next.prdata = 32'h0000_0000;
            endcase
        end else if (apb.psel && apb.penable && apb.pwrite &&
                     apb.paddr == OFF_MOVE_LEN) begin
            s_next.move_len = apb.pwdata[15:0];
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.prev_ctrl <= CTRL_NONE;
            // synced header starts idle so no false request edge follows
            s_reg.hdr_s1[HDR_CTRL_LSB +: 8] <= CTRL_NONE;
            s_reg.hdr_s2[HDR_CTRL_LSB +: 8] <= CTRL_NONE;
            s_reg.resp_ctrl <= RESP_PENDING;
            s_reg.params[0 +: 32] <= PARAM0_RESET;
            s_reg.move_len <= MOVE_LEN_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // response image
    assign response_header_in = {s_reg.resp_ctrl, s_reg.resp_sub,
                                 s_reg.resp_index}; // [R20]
    assign response_value_in = s_reg.resp_value;
    // done is low while moving, so it reads 0 with the new echo [R17]
    always_comb begin
        mode_status_word = 16'h0000;
        mode_status_word[MSTAT_MODE_LSB +: 7] = s_reg.active_mode[6:0];
        mode_status_word[MSTAT_TOGGLE_BIT] = s_reg.toggle_echo; // [R14]
        mode_status_word[MSTAT_FAULT_BIT] = s_reg.mode_fault; // [R22]
        mode_status_word[MSTAT_DONE_BIT] = !move_busy; // [R16] [R17]
    end
    assign drive_state_sel = s_reg.state_sel;

    // apb: zero wait states; unmapped addresses read zero, no error
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = s_reg.prdata;

endmodule : param_channel_mode_toggle
`default_nettype wire

// >>> param_channel_pkg.sv
package param_channel_pkg;

    // request control codes sent by the master
    localparam logic [7:0] CTRL_NONE = 8'h03;
    localparam logic [7:0] CTRL_READ = 8'h13;
    localparam logic [7:0] CTRL_WR_WORD = 8'h23;
    localparam logic [7:0] CTRL_WR_DWORD = 8'h33;
    // response control codes
    localparam logic [7:0] RESP_PENDING = 8'h03;
    localparam logic [7:0] RESP_OK_WORD = 8'h13;
    localparam logic [7:0] RESP_OK_DWORD = 8'h23;
    localparam logic [7:0] RESP_ERROR = 8'h73;
    // error numbers
    localparam logic [31:0] ERR_NO_PARAM = 32'h0000_1101;
    localparam logic [31:0] ERR_READ_ONLY = 32'h0000_1102;

    // header field positions
    localparam int HDR_INDEX_LSB = 0;
    localparam int HDR_SUB_LSB = 16;
    localparam int HDR_CTRL_LSB = 24;

    // mode command word layout
    localparam int MCMD_MODE_LSB = 0;
    localparam int MCMD_STATE_LSB = 8;
    localparam int MCMD_TOGGLE_BIT = 7;
    // mode status word layout
    localparam int MSTAT_MODE_LSB = 0;
    localparam int MSTAT_FAULT_BIT = 14;
    localparam int MSTAT_TOGGLE_BIT = 7;
    localparam int MSTAT_DONE_BIT = 15;

    // internal apb register offsets
    localparam logic [7:0] OFF_PARAM0 = 8'h00;
    localparam logic [7:0] OFF_PARAM1 = 8'h04;
    localparam logic [7:0] OFF_PARAM2 = 8'h08;
    localparam logic [7:0] OFF_PARAM3 = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_MOVE_LEN = 8'h14;

    // parameter addresses served by the local table
    localparam logic [15:0] PIDX_BASE = 16'h0065;
    localparam logic [7:0] PSUB_BASE = 8'h01;
    localparam int NUM_PARAMS = 4;
    localparam logic [31:0] PARAM0_RESET = 32'h0000_0000;
    localparam logic [15:0] MOVE_LEN_RESET = 16'h0010;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] sub;
        logic [15:0] index;
    } header_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef enum logic [1:0] {
        MV_IDLE = 2'b00,
        MV_RUN = 2'b01,
        MV_DONE = 2'b10
    } move_state_t;

    // header word to struct
    function automatic header_t unpack_hdr(input logic [31:0] w);
        header_t h;
        h.ctrl = w[HDR_CTRL_LSB +: 8];
        h.sub = w[HDR_SUB_LSB +: 8];
        h.index = w[HDR_INDEX_LSB +: 16];
        return h;
    endfunction : unpack_hdr

endpackage : param_channel_pkg

// >>> move_timer.sv
`timescale 1ns/1ns
`default_nettype none
module move_timer
    import param_channel_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control
    input wire logic start,
    input wire logic [15:0] length,
    // status
    output logic busy
);

    typedef struct packed {
        move_state_t st;
        logic [15:0] cnt;
    } tmr_t;

    tmr_t s_reg;
    tmr_t s_next;

    // a start during a running move restarts the count
    always_comb begin
        s_next = s_reg;
        case (s_reg.st)
            MV_IDLE, MV_DONE: begin
                if (start) begin
                    s_next.st = MV_RUN;
                    s_next.cnt = length;
                end
            end
            MV_RUN: begin
                if (start) begin
                    s_next.cnt = length;
                end else if (s_reg.cnt == 16'h0000) begin
                    s_next.st = MV_DONE;
                end else begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                end
            end
            default: begin
                s_next.st = MV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_reg <= '{st: MV_IDLE, cnt: 16'h0000};
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy = (s_reg.st == MV_RUN) || start;

endmodule : move_timer
`default_nettype wire

// >>> param_channel_mode_toggle_properties.sv
`timescale 1ns/1ns
`default_nettype none
module param_channel_mode_toggle_checker
    import param_channel_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // cyclic image
    input wire logic [31:0] request_header_out,
    input wire logic [31:0] request_value_out,
    input wire logic [15:0] drive_mode_command_word,
    input wire logic [31:0] response_header_in,
    input wire logic [31:0] response_value_in,
    input wire logic [15:0] mode_status_word,
    input wire logic [7:0] drive_state_sel,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // request code, answer code, and whether the target is in the table
    logic [7:0] rq;
    logic [7:0] rs;
    logic in_tab;
    assign rq = request_header_out[31:24];
    assign rs = response_header_in[31:24];
    // index below the base wraps high, so one compare covers both ends
    assign in_tab = request_header_out[23:16] == PSUB_BASE &&
        request_header_out[15:0] - PIDX_BASE < 16'(NUM_PARAMS);

    a_read_answer: assert property (
        $past(rq) == 8'h03 && rq == 8'h13 && in_tab
        ##1 $stable(request_header_out)[*2] |=> response_header_in ==
        {RESP_OK_DWORD, $past(request_header_out[23:0])})
        else $error("read answer wrong");
    a_bad_param: assert property (
        $past(rq) == 8'h03 && rq != 8'h03 && !in_tab
        ##1 $stable(request_header_out)[*2] |=> rs == RESP_ERROR &&
        response_value_in == ERR_NO_PARAM)
        else $error("missing parameter not reported");
    a_idle_pending: assert property (
        (rq == 8'h03)[*4] |-> rs == RESP_PENDING)
        else $error("idle answer not pending");
    a_resp_holds: assert property (
        (rq != 8'h03 && $stable(request_header_out))[*5]
        |-> $stable(response_header_in))
        else $error("answer changed under a steady request");
    a_no_restart: assert property (
        $past(rq) != 8'h03 && $changed(rq) && rq != 8'h03
        |-> ##3 $stable(rs))
        else $error("request started without idle first");
    a_toggle_echo: assert property (
        $changed(drive_mode_command_word[7]) ##1
        $stable(drive_mode_command_word[7])[*4]
        |-> mode_status_word[7] == drive_mode_command_word[7])
        else $error("toggle not echoed");
    a_echo_done_low: assert property (
        $changed(mode_status_word[7]) && !mode_status_word[14]
        |-> !mode_status_word[15])
        else $error("done high with new echo");
    a_done_bounded: assert property (
        $fell(mode_status_word[15]) |-> ##[1:600] mode_status_word[15])
        else $error("movement never finished");
    a_state_copy: assert property (
        $stable(drive_mode_command_word)[*4]
        |-> drive_state_sel == drive_mode_command_word[15:8])
        else $error("state not reflected");
    // the mode goes active with the toggle, three samples after the command
    a_mode_taken: assert property (
        $changed(mode_status_word[7])
        |-> mode_status_word[6:0] == $past(drive_mode_command_word[6:0], 3))
        else $error("active mode not taken at toggle");
endmodule : param_channel_mode_toggle_checker
`default_nettype wire

// >>> fieldbus_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master_model (
    // clock
    input wire logic clk_sys,
    // image towards the drive
    output logic [31:0] request_header_out,
    output logic [31:0] request_value_out,
    output logic [15:0] drive_mode_command_word,
    // image from the drive
    input wire logic [31:0] response_header_in,
    input wire logic [31:0] response_value_in,
    input wire logic [15:0] mode_status_word
);
    // start with no request pending
    initial begin
        request_header_out = 32'h0300_0000;
        request_value_out = 32'h0000_0000;
        drive_mode_command_word = 16'h0000;
    end
    // fields stay put until the answer is taken, then idle if asked
    task automatic xfer(input logic [7:0] c, input logic [23:0] tgt,
            input logic [31:0] v, input bit idle,
            output logic [31:0] h, output logic [31:0] d);
        @(posedge clk_sys);
        request_header_out <= {c, tgt};
        request_value_out <= v;
        repeat (4) @(posedge clk_sys);
        h = response_header_in;
        d = response_value_in;
        if (idle) begin
            request_header_out <= {8'h03, tgt};
            repeat (4) @(posedge clk_sys);
        end
    endtask : xfer
    // select operating state and mode, toggle bit untouched
    task automatic set_mode(input logic [7:0] st, input logic [6:0] md);
        @(posedge clk_sys);
        drive_mode_command_word <= {st, drive_mode_command_word[7], md};
    endtask : set_mode
    // flip the toggle, wait for its echo, then for done
    task automatic toggle(output logic e, output bit ok);
        int n;
        logic t;
        t = ~drive_mode_command_word[7];
        @(posedge clk_sys);
        drive_mode_command_word[7] <= t;
        for (n = 0; n < 20 && mode_status_word[7] !== t; n++)
            @(posedge clk_sys);
        e = mode_status_word[15];
        for (n = 0; n < 600 && mode_status_word[15] !== 1'b1; n++)
            @(posedge clk_sys);
        ok = mode_status_word[7] === t && mode_status_word[15] === 1'b1;
    endtask : toggle
endmodule : fieldbus_master_model
`default_nettype wire

// >>> param_channel_mode_toggle_bench.sv
`timescale 1ns/1ns
`default_nettype none
module param_channel_mode_toggle_bench
    import param_channel_pkg::*;
;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [31:0] request_header_out, request_value_out, prdata, pwdata;
    logic [31:0] response_header_in, response_value_in, h, d, r;
    logic [15:0] drive_mode_command_word, mode_status_word;
    logic [7:0] drive_state_sel, paddr;
    logic [23:0] tgt;
    logic e;
    int failures = 0;
    int compares = 0;

    param_channel_mode_toggle param_channel_mode_toggle_inst (.clk_sys,
        .rst_n, .request_header_out, .request_value_out,
        .drive_mode_command_word, .response_header_in, .response_value_in,
        .mode_status_word, .drive_state_sel, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr);
    fieldbus_master_model master (.clk_sys, .request_header_out,
        .request_value_out, .drive_mode_command_word, .response_header_in,
        .response_value_in, .mode_status_word);

    // clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            failures++;
            tally_and_finish();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // a toggle that never completes ends the run
    task automatic tog();
        bit ok;
        master.toggle(e, ok);
        if (!ok) begin
            failures++;
            tally_and_finish();
        end
    endtask : tog

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        check("idle header", response_header_in, 32'h0300_0000);
        check("status", {16'h0, mode_status_word}, 32'h0000_8000);
        apb(1'b0, OFF_MOVE_LEN, 32'h0, r);
        check("move length", r, {16'h0, MOVE_LEN_RESET});
        apb(1'b0, 8'h20, 32'h0, r);
        check("unmapped", r, 32'h0);
        $display("reset test done");
        // reads of every slot, value field of the request is junk
        for (int k = 0; k < 3; k++)
            apb(1'b1, 8'(4 * k), 32'hA5A5_0000 | 32'(k), r);
        for (int k = 0; k < 4; k++) begin
            tgt = {PSUB_BASE, PIDX_BASE + 16'(k)};
            master.xfer(CTRL_READ, tgt, 32'hDEAD_BEEF, 1'b1, h, d);
            check("read header", h, {RESP_OK_DWORD, tgt});
            check("read value", d, k < 3 ? 32'hA5A5_0000 | 32'(k)
                : 32'h0000_0010);
        end
        $display("read test done");
        tgt = {PSUB_BASE, 16'h0066};
        master.xfer(CTRL_WR_DWORD, tgt, 32'h1234_5678, 1'b1, h, d);
        check("dword header", h, {RESP_OK_DWORD, tgt});
        check("dword value", d, 32'h1234_5678);
        apb(1'b0, OFF_PARAM1, 32'h0, r);
        check("dword stored", r, 32'h1234_5678);
        tgt = {PSUB_BASE, 16'h0067};
        master.xfer(CTRL_WR_WORD, tgt, 32'hFFFF_BEEF, 1'b1, h, d);
        check("word header", h, {RESP_OK_WORD, tgt});
        check("word value", d, 32'hA5A5_BEEF);
        tgt = {8'h32, 16'h0067};
        master.xfer(CTRL_WR_DWORD, tgt, 32'h0000_00DE, 1'b1, h, d);
        check("missing header", h, {RESP_ERROR, tgt});
        check("missing value", d, ERR_NO_PARAM);
        tgt = {PSUB_BASE, 16'h0068};
        master.xfer(CTRL_WR_DWORD, tgt, 32'h0000_0005, 1'b1, h, d);
        check("read-only value", d, ERR_READ_ONLY);
        apb(1'b0, OFF_MOVE_LEN, 32'h0, r);
        check("read-only kept", r, 32'h0000_0010);
        $display("write test done");
        // held read refreshes its value; a code change without idle is no
        tgt = {PSUB_BASE, PIDX_BASE};
        master.xfer(CTRL_READ, tgt, 32'h0, 1'b0, h, d);
        apb(1'b1, OFF_PARAM0, 32'h0BAD_F00D, r);
        repeat (2) @(posedge clk_sys);
        check("refresh", response_value_in, 32'h0BAD_F00D);
        master.xfer(CTRL_WR_DWORD, tgt, 32'h7777_7777, 1'b1, h, d);
        check("no restart", h, {RESP_OK_DWORD, tgt});
        apb(1'b0, OFF_PARAM0, 32'h0, r);
        check("not written", r, 32'h0BAD_F00D);
        $display("hold test done");
        master.set_mode(8'hA5, 7'h05);
        repeat (5) @(posedge clk_sys);
        check("state", {24'h0, drive_state_sel}, 32'h0000_00A5);
        repeat (2) begin
            tog();
            check("done at echo", {31'h0, e}, 32'h0);
        end
        // the commanded mode only becomes active with a toggle
        check("mode", {25'h0, mode_status_word[6:0]}, 32'h5);
        apb(1'b1, OFF_MOVE_LEN, 32'h0000_0001, r);
        tog();
        apb(1'b1, OFF_MOVE_LEN, 32'h0000_0000, r);
        tog();
        check("fault", {31'h0, mode_status_word[MSTAT_FAULT_BIT]},
            32'h1);
        apb(1'b0, OFF_STATUS, 32'h0, r);
        check("status read", r, 32'h0000_C005);
        $display("mode test done");
        tally_and_finish();
    end
endmodule : param_channel_mode_toggle_bench

bind param_channel_mode_toggle param_channel_mode_toggle_checker checker_inst (
    .clk_sys, .rst_n, .request_header_out, .request_value_out,
    .drive_mode_command_word, .response_header_in, .response_value_in,
    .mode_status_word, .drive_state_sel, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
`default_nettype wire
